// *** dv/emb_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module emb_mem_model (
	input wire logic clock,
	input wire logic [7:0] port_o,
	input wire logic port_oe,
	output logic [7:0] port_i,
	input wire logic [7:0] high_port,
	input wire logic ale,
	input wire logic fetch_n,
	input wire logic rd_n,
	input wire logic wr_n
);
	logic [7:0] mem [0:255];
	logic [7:0] low_q = 8'h00;
	logic [7:0] page_q = 8'h00;
	logic [7:0] churn_q = 8'h00;
	wire logic [7:0] key = page_q ^ high_port;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
	end
	// Released bus churns so a stale byte is never read back
	assign port_i = !fetch_n ? (low_q ^ high_port) :
		!rd_n ? (mem[low_q] ^ key) : churn_q;
	always @(posedge clock) begin
		churn_q <= churn_q + 8'h35;
		if (ale) begin
			low_q <= port_o;
			page_q <= high_port;
		end
		if (!wr_n && port_oe) mem[low_q] <= port_o ^ key;
	end
endmodule
`default_nettype wire

// *** dv/external_memory_bus_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module external_memory_bus_tb_top import emb_pkg::*;;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic strap = 1'b0;
	logic idle_m = 1'b0;
	logic pdown = 1'b0;
	logic req_valid = 1'b0;
	logic [1:0] req_op = 2'b00;
	logic [23:0] req_addr = 24'h00_0000;
	logic [7:0] req_wdata = 8'h00;
	logic req_ready, rsp_valid, rsp_internal, oe, ale, fetch_n, rd_n, wr_n;
	logic [7:0] rsp_data, port_o, port_i, high_port;
	logic code_int;
	int fails = 0;
	int checks = 0;
	logic [8:0] exp_q [$];
	logic [7:0] tb_mem [0:255];

	emb_bus dut (.clock(clock), .reset(reset),
		.external_access_select(strap), .idle_mode(idle_m),
		.power_down_mode(pdown), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_internal(rsp_internal), .muxed_low_bus_port_o(port_o),
		.muxed_low_bus_port_oe(oe), .muxed_low_bus_port_i(port_i),
		.high_address_port(high_port), .addr_latch_strobe(ale),
		.program_fetch_strobe_n(fetch_n), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .code_from_internal(code_int));
	emb_mem_model mem (.clock(clock), .port_o(port_o), .port_oe(oe),
		.port_i(port_i), .high_port(high_port), .ale(ale),
		.fetch_n(fetch_n), .rd_n(rd_n), .wr_n(wr_n));

	initial begin
		forever #12.5 clock = ~clock;
	end

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic send(input logic [1:0] op, input logic [23:0] a,
		input logic [7:0] wd);
		logic [7:0] hi;
		hi = a[15:8] ^ a[23:16];
		@(negedge clock);
		for (int n = 0; n < 200 && !req_ready; n++) @(negedge clock);
		req_op = op;
		req_addr = a;
		req_wdata = wd;
		req_valid = 1'b1;
		if (op == EMB_OP_WRITE) begin
			tb_mem[a[7:0]] = wd ^ hi;
			exp_q.push_back(9'h000);
		end else if (op == EMB_OP_READ) begin
			exp_q.push_back({1'b0, tb_mem[a[7:0]] ^ hi});
		end else if (strap && a[15:0] <= 16'h1FFF) begin
			exp_q.push_back(9'h100);
		end else begin
			exp_q.push_back({1'b0, a[7:0] ^ a[15:8]});
		end
	endtask

	task automatic drain();
		@(negedge clock);
		req_valid = 1'b0;
		for (int n = 0; n < 2000 && exp_q.size() > 0; n++) @(negedge clock);
		if (exp_q.size() > 0) check(9'h000, 9'h1ff);
	endtask

	task automatic do_reset(input logic s);
		@(negedge clock);
		reset = 1'b1;
		strap = s;
		repeat (8) @(negedge clock);
		reset = 1'b0;
		repeat (2) @(negedge clock);
		check({8'h00, code_int}, {8'h00, s});
	endtask

	task automatic random_mix(input int count);
		for (int i = 0; i < count; i++) begin
			send(2'($urandom % 3), 24'($urandom), 8'($urandom));
		end
		drain();
	endtask

	// Response outputs are registered, so results are sampled mid-cycle
	always @(negedge clock) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) check(9'h000, 9'h1ff);
			else check({rsp_internal, rsp_data}, exp_q.pop_front());
		end
	end

	initial begin
		#500000;
		fails++;
		conclude();
	end

	initial begin
		void'($urandom(30));
		for (int i = 0; i < 256; i++) tb_mem[i] = 8'h00;
		do_reset(1'b0);
		send(EMB_OP_FETCH, 24'h00_0000, 8'h00);
		random_mix(40);
		@(negedge clock);
		idle_m = 1'b1;
		repeat (8) @(negedge clock);
		check({7'h00, ale, fetch_n}, 9'h003);
		for (int i = 0; i < 16; i++) send(EMB_OP_FETCH, 24'($urandom), 8'h00);
		@(negedge clock);
		req_valid = 1'b0;
		check({8'h00, req_ready}, 9'h000);
		pdown = 1'b1;
		repeat (4) @(negedge clock);
		check({7'h00, ale, fetch_n}, 9'h000);
		pdown = 1'b0;
		idle_m = 1'b0;
		drain();
		do_reset(1'b1);
		send(EMB_OP_FETCH, 24'h00_0000, 8'h00);
		send(EMB_OP_FETCH, 24'h00_1fff, 8'h00);
		send(EMB_OP_FETCH, 24'h00_2000, 8'h00);
		send(EMB_OP_FETCH, 24'h00_ffff, 8'h00);
		random_mix(40);
		conclude();
	end
endmodule
`default_nettype wire

// *** rtl/emb_bus.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "emb_map.svh"
module emb_bus
	import emb_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic external_access_select,
	input wire logic idle_mode,
	input wire logic power_down_mode,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_op,
	input wire logic [23:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_internal,
	output logic [7:0] muxed_low_bus_port_o,
	output logic muxed_low_bus_port_oe,
	input wire logic [7:0] muxed_low_bus_port_i,
	output logic [7:0] high_address_port,
	output logic addr_latch_strobe,
	output logic program_fetch_strobe_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic code_from_internal
);
	logic q_valid;
	logic q_ready;
	logic [`EMB_REQ_W-1:0] q_data;
	emb_state_t st_q;
	emb_state_t st_d;
	logic [23:0] addr_q;
	logic [7:0] wdata_q;
	emb_op_t op_q;
	logic [7:0] p0_q;
	logic p0_oe_q;
	logic [7:0] p2_q;
	logic ale_q;
	logic program_fetch_strobe_n_q;
	logic rd_n_q;
	logic wr_n_q;
	logic rsp_valid_q;
	logic [7:0] rsp_data_q;
	logic rsp_int_q;
	logic ea_q;
	logic held_q;

	// Buffered requests; the core stalls on req_ready when full
	emb_fifo #(
		.WIDTH(`EMB_REQ_W),
		.DEPTH(`EMB_FIFO_DEPTH),
		.AW(`EMB_FIFO_AW)
	) u_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data({req_op, req_addr[23:0], req_wdata}),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);

	function automatic logic fetch_internal(input logic ea,
		input logic [15:0] pc);
		fetch_internal = ea && (pc <= `EMB_INT_TOP);
	endfunction

	wire emb_op_t q_op = emb_op_t'(q_data[`EMB_OP_HI:`EMB_OP_LO]);
	wire [15:0] q_pc = q_data[`EMB_ADDR_HI-8:`EMB_DATA_HI+1];
	wire q_int = (q_op == EMB_OP_FETCH) && fetch_internal(ea_q, q_pc);
	wire halted = idle_mode || power_down_mode;
	wire start = (st_q == EMB_ST_IDLE) && q_valid && !halted;
	// Internal fetches never touch the pins
	wire start_ext = start && !q_int;
	wire is_fetch = (op_q == EMB_OP_FETCH);
	assign q_ready = start;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			EMB_ST_IDLE: begin
				if (start_ext) begin
					st_d = EMB_ST_ADDR;
				end
			end
			EMB_ST_ADDR: st_d = EMB_ST_LATCH;
			EMB_ST_LATCH: st_d = EMB_ST_STROBE;
			EMB_ST_STROBE: st_d = EMB_ST_SAMPLE;
			EMB_ST_SAMPLE: st_d = EMB_ST_IDLE;
			default: st_d = EMB_ST_IDLE;
		endcase
	end

	// Strap sampled on reset release only
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ea_q <= 1'b0;
			held_q <= 1'b0;
		end else if (!held_q) begin
			ea_q <= external_access_select;
			held_q <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st_q <= EMB_ST_IDLE;
			addr_q <= 24'h00_0000;
			wdata_q <= 8'h00;
			op_q <= EMB_OP_FETCH;
		end else begin
			st_q <= st_d;
			if (start_ext) begin
				op_q <= q_op;
				addr_q <= q_data[`EMB_ADDR_HI:`EMB_DATA_HI+1];
				wdata_q <= q_data[`EMB_DATA_HI:0];
			end
		end
	end

	// Pin drive: ports only ever carry bus cycles
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			p0_q <= 8'h00;
			p0_oe_q <= 1'b0;
			p2_q <= 8'h00;
			ale_q <= 1'b0;
			program_fetch_strobe_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
		end else if (power_down_mode && st_q == EMB_ST_IDLE) begin
			ale_q <= 1'b0;
			program_fetch_strobe_n_q <= 1'b0;
		end else if (idle_mode && st_q == EMB_ST_IDLE) begin
			ale_q <= 1'b1;
			program_fetch_strobe_n_q <= 1'b1;
		end else begin
			unique case (st_q)
				EMB_ST_IDLE: begin
					ale_q <= 1'b0;
					program_fetch_strobe_n_q <= 1'b1;
				end
				EMB_ST_ADDR: begin
					p0_q <= addr_q[7:0];
					p0_oe_q <= 1'b1;
					// Page byte first on data accesses so the extra latch catches it; fetches drive the PC high byte
					p2_q <= is_fetch ? addr_q[15:8] : addr_q[23:16];
					ale_q <= 1'b1;
				end
				EMB_ST_LATCH: begin
					ale_q <= 1'b0;
					p2_q <= addr_q[15:8];
					p0_q <= wdata_q;
					p0_oe_q <= (op_q == EMB_OP_WRITE);
				end
				EMB_ST_STROBE: begin
					program_fetch_strobe_n_q <= !is_fetch;
					rd_n_q <= !(op_q == EMB_OP_READ);
					wr_n_q <= !(op_q == EMB_OP_WRITE);
				end
				EMB_ST_SAMPLE: begin
					program_fetch_strobe_n_q <= 1'b1;
					rd_n_q <= 1'b1;
					wr_n_q <= 1'b1;
					p0_oe_q <= 1'b0;
				end
				default: begin
					p0_oe_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 8'h00;
			rsp_int_q <= 1'b0;
		end else begin
			rsp_valid_q <= 1'b0;
			if (start && q_int) begin
				rsp_valid_q <= 1'b1;
				rsp_int_q <= 1'b1;
				rsp_data_q <= 8'h00;
			end else if (st_q == EMB_ST_SAMPLE) begin
				rsp_valid_q <= 1'b1;
				rsp_int_q <= 1'b0;
				rsp_data_q <= (op_q == EMB_OP_WRITE) ? 8'h00 : muxed_low_bus_port_i;
			end
		end
	end

	assign muxed_low_bus_port_o = p0_q;
	assign muxed_low_bus_port_oe = p0_oe_q;
	assign high_address_port = p2_q;
	assign addr_latch_strobe = ale_q;
	assign program_fetch_strobe_n = program_fetch_strobe_n_q;
	assign read_strobe_n = rd_n_q;
	assign write_strobe_n = wr_n_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rsp_data_q;
	assign rsp_internal = rsp_int_q;
	assign code_from_internal = ea_q;

	AST_ALE_LOW_VALID: assert property (@(posedge clock) disable iff (reset)
		$rose(addr_latch_strobe) && !idle_mode |-> muxed_low_bus_port_oe)
		else $error("Latch strobe without driven address");
	AST_PROGRAM_FETCH_STROBE_AFTER_ALE: assert property (@(posedge clock) disable iff (reset)
		$fell(program_fetch_strobe_n) && !power_down_mode |->
		$past(addr_latch_strobe, 2))
		else $error("Fetch strobe not two cycles after latch");
	AST_FETCH_FLOAT: assert property (@(posedge clock) disable iff (reset)
		!program_fetch_strobe_n && !power_down_mode |-> !muxed_low_bus_port_oe)
		else $error("Muxed port driven during fetch strobe");
	AST_READ_FLOAT: assert property (@(posedge clock) disable iff (reset)
		!read_strobe_n |-> !muxed_low_bus_port_oe)
		else $error("Muxed port driven during read");
	AST_WRITE_DRIVE: assert property (@(posedge clock) disable iff (reset)
		!write_strobe_n |-> muxed_low_bus_port_oe && !addr_latch_strobe)
		else $error("Write strobe without write data");
	AST_STROBE_EXCL: assert property (@(posedge clock) disable iff (reset)
		!(!read_strobe_n && !write_strobe_n) &&
		!(!program_fetch_strobe_n && !read_strobe_n && !power_down_mode))
		else $error("Overlapping memory strobes");
	AST_IDLE_HIGH: assert property (@(posedge clock) disable iff (reset)
		idle_mode && !power_down_mode && st_q == EMB_ST_IDLE ##1
		st_q == EMB_ST_IDLE |-> addr_latch_strobe && program_fetch_strobe_n)
		else $error("Strobes not high in idle");
	AST_PD_LOW: assert property (@(posedge clock) disable iff (reset)
		power_down_mode && st_q == EMB_ST_IDLE ##1 st_q == EMB_ST_IDLE |->
		!addr_latch_strobe && !program_fetch_strobe_n)
		else $error("Strobes not low in power-down");
	AST_PAGE_THEN_HIGH: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_LATCH && op_q != EMB_OP_FETCH |=>
		high_address_port == addr_q[15:8] && $past(high_address_port) == addr_q[23:16])
		else $error("High port sequence wrong");

	AST_ALE_IN_LATCH: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_LATCH |-> addr_latch_strobe)
		else $error("Latch strobe missing after address phase");

	AST_ALE_DROPS: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_STROBE |-> !addr_latch_strobe)
		else $error("Latch strobe still high at strobe phase");

	AST_ALE_ONLY_LATCH: assert property (@(posedge clock) disable iff (reset)
		addr_latch_strobe && !idle_mode && !$past(idle_mode) |->
		st_q == EMB_ST_LATCH)
		else $error("Latch strobe outside address phase");

	AST_LOW_ADDR_ON_PORT: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_LATCH |->
		muxed_low_bus_port_oe && muxed_low_bus_port_o == addr_q[7:0])
		else $error("Low address byte not driven while latched");

	AST_FETCH_HIGH_BYTE: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_LATCH && op_q == EMB_OP_FETCH |->
		high_address_port == addr_q[15:8])
		else $error("Fetch high byte missing at latch");

	AST_PAGE_AT_LATCH: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_LATCH && op_q != EMB_OP_FETCH |->
		high_address_port == addr_q[23:16])
		else $error("Page byte missing at latch");

	AST_HIGH_HOLDS: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_SAMPLE |-> high_address_port == addr_q[15:8])
		else $error("High byte not held during strobe");

	AST_FETCH_STROBE: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_SAMPLE && op_q == EMB_OP_FETCH |->
		!program_fetch_strobe_n && read_strobe_n && write_strobe_n)
		else $error("Wrong strobe for code fetch");

	AST_READ_STROBE: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_SAMPLE && op_q == EMB_OP_READ |->
		!read_strobe_n && program_fetch_strobe_n && write_strobe_n &&
		!muxed_low_bus_port_oe)
		else $error("Wrong strobe or drive for data read");

	AST_WRITE_STROBE: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_SAMPLE && op_q == EMB_OP_WRITE |->
		!write_strobe_n && read_strobe_n && program_fetch_strobe_n &&
		muxed_low_bus_port_oe && muxed_low_bus_port_o == wdata_q)
		else $error("Wrong strobe or data for data write");

	AST_PROGRAM_FETCH_STROBE_QUIET_DATA: assert property (@(posedge clock) disable iff (reset)
		op_q != EMB_OP_FETCH && st_q != EMB_ST_IDLE |->
		program_fetch_strobe_n)
		else $error("Fetch strobe during data cycle");

	AST_BUS_RELEASED: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_IDLE && $past(st_q) == EMB_ST_SAMPLE |->
		read_strobe_n && write_strobe_n && program_fetch_strobe_n &&
		!muxed_low_bus_port_oe)
		else $error("Bus not released after cycle");

	AST_OE_IN_CYCLE: assert property (@(posedge clock) disable iff (reset)
		muxed_low_bus_port_oe |-> st_q == EMB_ST_LATCH ||
		st_q == EMB_ST_STROBE || st_q == EMB_ST_SAMPLE)
		else $error("Muxed port driven outside a bus cycle");

	AST_CYCLE_ORDER: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_ADDR |=> st_q == EMB_ST_LATCH ##1
		st_q == EMB_ST_STROBE ##1 st_q == EMB_ST_SAMPLE ##1
		st_q == EMB_ST_IDLE)
		else $error("Bus cycle phases out of order");

	AST_EXT_RSP: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_SAMPLE |=> rsp_valid && !rsp_internal)
		else $error("No response after external cycle");

	AST_WRITE_RSP_ZERO: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_SAMPLE && op_q == EMB_OP_WRITE |=> rsp_data == 8'h00)
		else $error("Write response carries data");

	AST_READ_SAMPLED: assert property (@(posedge clock) disable iff (reset)
		st_q == EMB_ST_SAMPLE && op_q != EMB_OP_WRITE |=>
		rsp_data == $past(muxed_low_bus_port_i))
		else $error("Returned byte not the sampled port");

	AST_INT_NO_PINS: assert property (@(posedge clock) disable iff (reset)
		start && q_int |=> st_q == EMB_ST_IDLE && rsp_valid && rsp_internal)
		else $error("Internal fetch touched the bus");

	AST_EXT_STRAP_FETCH: assert property (@(posedge clock) disable iff (reset)
		start && q_op == EMB_OP_FETCH && !code_from_internal |=>
		st_q == EMB_ST_ADDR)
		else $error("External strap fetch stayed on chip");

	AST_HIGH_PC_EXTERNAL: assert property (@(posedge clock) disable iff (reset)
		start && q_op == EMB_OP_FETCH && q_pc > `EMB_INT_TOP |=>
		st_q == EMB_ST_ADDR)
		else $error("Fetch above on-chip space stayed on chip");

	AST_HALT_NO_START: assert property (@(posedge clock) disable iff (reset)
		halted && st_q == EMB_ST_IDLE |=> st_q == EMB_ST_IDLE)
		else $error("Bus cycle started while halted");

	AST_IDLE_PORT_HOLD: assert property (@(posedge clock) disable iff (reset)
		idle_mode && st_q == EMB_ST_IDLE ##1 st_q == EMB_ST_IDLE |->
		$stable(muxed_low_bus_port_o) && $stable(high_address_port) &&
		$stable(muxed_low_bus_port_oe))
		else $error("Port pins moved in idle");

	AST_PD_PORT_HOLD: assert property (@(posedge clock) disable iff (reset)
		power_down_mode && st_q == EMB_ST_IDLE ##1 st_q == EMB_ST_IDLE |->
		$stable(muxed_low_bus_port_o) && $stable(high_address_port) &&
		$stable(muxed_low_bus_port_oe))
		else $error("Port pins moved in power-down");
endmodule
`default_nettype wire

// *** rtl/emb_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module emb_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire empty = (wr_q == rd_q);
	wire push = in_valid && !full;
	wire pop = out_valid && out_ready;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_q[AW-1:0]];
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/emb_map.svh ***
// Behaviour
// - Program space 64 Kbytes, data space 16 Mbytes (24-bit pointer).
// - Select pin high: execution starts at on-chip location 0.
// - Select pin low: execution starts at external location 0.
// - Fetches above 1FFF hex always go to external program memory.
// - Both 8-bit ports are reserved for the bus during external fetches.
// - Fetch drives low PC byte, then floats the muxed port.
// - Address-latch strobe pulses while the low address byte is valid.
// - Fetch drives high PC byte, then asserts fetch strobe, samples code.
// - Program addresses are always issued as full 16 bits.
// - Bus ports serve data accesses too, never general-purpose I/O.
// - Data accesses interleave with fetches; spaces stay independent.
// - Data access latches pointer low byte before any data on port.
// - High port shows page byte for latch, then pointer high byte.
// - Idle: both strobes high, port pins hold their states.
// - Power-down: both strobes low, port pins hold their levels.
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH
`define EMB_INT_TOP 16'h1FFF
`define EMB_RESET_PC 16'h0000
`define EMB_FIFO_DEPTH 16
`define EMB_FIFO_AW 4
`define EMB_REQ_W 34
`define EMB_OP_HI 33
`define EMB_OP_LO 32
`define EMB_ADDR_HI 31
`define EMB_DATA_HI 7
`endif

// *** rtl/emb_pkg.sv ***
package emb_pkg;
	typedef enum logic [1:0] {
		EMB_OP_FETCH = 2'b00,
		EMB_OP_READ = 2'b01,
		EMB_OP_WRITE = 2'b10
	} emb_op_t;
	typedef enum logic [2:0] {
		EMB_ST_IDLE = 3'b000,
		EMB_ST_ADDR = 3'b001,
		EMB_ST_LATCH = 3'b010,
		EMB_ST_STROBE = 3'b011,
		EMB_ST_SAMPLE = 3'b100
	} emb_state_t;
endpackage
